// ### fault_supervisor_pkg.sv
package fault_supervisor_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam longint CLK_HZ = 64'd50000000;
  localparam int unsigned GATE_WIN_SHORT_MS = 2000;
  localparam int unsigned GATE_WIN_LONG_MS = 4000;
  localparam int unsigned PWAIT_MS = 3600000;
  localparam int unsigned OVR_OFF_MS = 120000;
  localparam int unsigned OVR_LOCK_MS = 150000;
  localparam int unsigned SKEW_MS = 500;
  localparam int unsigned SYNC_MS = 60000;
  localparam int unsigned RST_HOLD_MS = 150000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = int'(CLK_HZ / 64'd1000000) * TICK_US;

  localparam int CNT_W = 32;

  // ------------------------------------------------------------
  // Display codes (letter plus two decimal digits)
  // ------------------------------------------------------------
  typedef logic [7:0] code_t;
  localparam code_t C_NONE = 8'h00;
  localparam code_t C_GND_A = 8'h06;
  localparam code_t C_VCC_A = 8'h07;
  localparam code_t C_GND_B = 8'h08;
  localparam code_t C_VCC_B = 8'h09;
  localparam code_t C_OUT_U1 = 8'h10;
  localparam code_t C_OUT_U2 = 8'h11;
  localparam code_t C_UNDERV = 8'h14;
  localparam code_t C_OVERV = 8'h15;
  localparam code_t C_OVERV_HI = 8'h16;
  localparam code_t C_TEMP_HI = 8'h18;
  localparam code_t C_TEMP_LO = 8'h19;
  localparam code_t C_LINE0 = 8'h22;
  localparam code_t C_LINE1 = 8'h23;
  localparam code_t C_LINE2 = 8'h24;
  localparam code_t C_RST_HOLD = 8'h39;
  localparam code_t C_MODE_CHG = 8'h41;
  localparam code_t C_BEAM_CFG = 8'h60;
  localparam code_t C_RESP = 8'h61;
  localparam code_t C_BLANK = 8'h62;
  localparam code_t C_LATE = 8'h64;
  localparam code_t C_PWAIT = 8'h65;
  localparam code_t C_OVR_START = 8'h66;
  localparam code_t C_OVR_HOLD = 8'h67;
  localparam code_t C_OVR_TIME = 8'h68;
  localparam code_t C_SKEW = 8'h69;
  localparam code_t C_FIELD = 8'h70;

  localparam logic [7:0] LETTER_E = 8'h45;

  // Event bit positions in the status / mask registers
  localparam int EV_OUTPUT = 0;
  localparam int EV_SUPPLY = 1;
  localparam int EV_TEMP = 2;
  localparam int EV_LINE = 3;
  localparam int EV_BUTTON = 4;
  localparam int EV_CONFIG = 5;
  localparam int EV_GATING = 6;
  localparam int EV_LOCK = 7;
  localparam int EV_W = 8;

  // ------------------------------------------------------------
  // Register map (word index on the plain port)
  // ------------------------------------------------------------
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_MASK = 4'h1;
  localparam logic [3:0] A_CODE = 4'h2;
  localparam logic [3:0] A_MODE = 4'h3;
  localparam logic [3:0] A_CLEAR = 4'h4;

  localparam logic [2:0] MODE_1 = 3'h1;
  localparam logic [2:0] MODE_4 = 3'h4;
  localparam logic [2:0] MODE_6 = 3'h6;
  localparam logic [2:0] MODE_RST = 3'h1;

  typedef enum logic [2:0] {
    G_IDLE = 3'b000,
    G_ARMED = 3'b001,
    G_PWAIT = 3'b010,
    G_OVERRIDE = 3'b011,
    G_DONE = 3'b100
  } gate_e;

  function automatic int unsigned ms_cyc(input int unsigned ms);
    return ms;
  endfunction : ms_cyc

endpackage : fault_supervisor_pkg

// ### fault_and_gating_supervisor.sv
`timescale 1ns/1ps
module fault_and_gating_supervisor #(
  parameter int unsigned TICK = fault_supervisor_pkg::TICK_CYC
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic [1:0] GND_SHORT,
  input wire logic [1:0] VCC_SHORT,
  input wire logic [1:0] OUTPUT_FAULT,
  input wire logic UNDERVOLT,
  input wire logic OVERVOLT,
  input wire logic OVERVOLT_HIGH,
  input wire logic TEMP_HIGH,
  input wire logic TEMP_LOW,
  input wire logic [2:0] LINE_DRIVE,
  input wire logic [2:0] LINE_READBACK,
  input wire logic RESTART_BUTTON,
  input wire logic MODE_CHANGE,
  input wire logic BEAM_CFG_FAULT,
  input wire logic RESPONSE_OVERRUN,
  input wire logic BLANK_OVERLAP,
  input wire logic FIELD_BROKEN,
  input wire logic SYNC_BROKEN,
  input wire logic GATING_START,
  input wire logic GATING_HOLD_SIGNAL,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic SAFETY_OUTPUT_A,
  output logic SAFETY_OUTPUT_B,
  output logic LOCKED,
  output logic [7:0] DISPLAY_LETTER,
  output logic [7:0] DISPLAY_CODE,
  output logic IRQ
);

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  localparam int NIN = 26;
  logic [NIN-1:0] pins;
  logic [NIN-1:0] s1_reg;
  logic [NIN-1:0] s2_reg;
  assign pins = {GND_SHORT, VCC_SHORT, OUTPUT_FAULT, UNDERVOLT, OVERVOLT, OVERVOLT_HIGH, TEMP_HIGH,
                 TEMP_LOW, LINE_READBACK, RESTART_BUTTON, MODE_CHANGE, BEAM_CFG_FAULT,
                 RESPONSE_OVERRUN, BLANK_OVERLAP, FIELD_BROKEN, SYNC_BROKEN, GATING_START,
                 GATING_HOLD_SIGNAL, LINE_DRIVE};
  // Not reset: they already hold the pins when reset drops, so no false line toggle follows it
  always_ff @(posedge CLK) begin
    s1_reg <= pins;
    s2_reg <= s1_reg;
  end

  logic [1:0] gnd_s, vcc_s, ofl_s;
  logic uv_s, ov_s, ovh_s, th_s, tl_s, btn_s, mchg_s, cfg_s, resp_s, blk_s, fld_s, sync_s, cs_s, hold_s;
  logic [2:0] rb_s, drv_s;
  assign {gnd_s, vcc_s, ofl_s, uv_s, ov_s, ovh_s, th_s, tl_s, rb_s, btn_s, mchg_s, cfg_s, resp_s,
          blk_s, fld_s, sync_s, cs_s, hold_s, drv_s} = s2_reg;

  // ------------------------------------------------------------
  // Millisecond tick and timers
  // ------------------------------------------------------------
  logic [31:0] pre_reg;
  logic tick;
  assign tick = (pre_reg == TICK - 1);
  always_ff @(posedge CLK) begin
    if (RST || tick) pre_reg <= '0;
    else pre_reg <= pre_reg + 32'h1;
  end

  function automatic logic [31:0] bump(input logic [31:0] c, input logic run, input logic t);
    if (!run) return 32'h0;
    return (t && c != 32'hffffffff) ? c + 32'h1 : c;
  endfunction : bump

  // ------------------------------------------------------------
  // Decode helpers
  // ------------------------------------------------------------
  function automatic logic reg_write(input logic wr, input logic [3:0] addr, input logic [3:0] target);
    return wr && (addr == target);
  endfunction : reg_write

  // A read-back line flipping in the same cycle as another line counts as cross-talk
  function automatic logic joint_toggle(input logic [2:0] t, input int idx);
    logic [2:0] others;
    others = t & ~(3'h1 << idx);
    return t[idx] && (others != 3'h0);
  endfunction : joint_toggle

  logic [31:0] btn_ms_reg;
  logic [31:0] gate_ms_reg;
  logic [31:0] skew_ms_reg;
  logic [31:0] sync_ms_reg;
  fault_supervisor_pkg::gate_e gate_reg, gate_next;
  logic [2:0] mode_reg;
  logic locked_reg;
  logic prev_cs_reg;
  logic [2:0] prev_rb_reg;

  always_ff @(posedge CLK) begin
    if (RST) begin
      btn_ms_reg <= '0;
      sync_ms_reg <= '0;
      skew_ms_reg <= '0;
    end else begin
      btn_ms_reg <= bump(btn_ms_reg, btn_s, tick);
      sync_ms_reg <= bump(sync_ms_reg, sync_s, tick);
      skew_ms_reg <= bump(skew_ms_reg, cs_s != hold_s, tick);
    end
  end

  // ------------------------------------------------------------
  // Gating sequence
  // ------------------------------------------------------------
  logic dual;
  logic [31:0] win_ms;
  assign dual = (mode_reg == fault_supervisor_pkg::MODE_1) || (mode_reg == fault_supervisor_pkg::MODE_6);
  assign win_ms = (mode_reg == fault_supervisor_pkg::MODE_4) ? fault_supervisor_pkg::GATE_WIN_SHORT_MS
                                                             : fault_supervisor_pkg::GATE_WIN_LONG_MS;

  logic late_ev, pwait_ev, ovr_cs_ev, ovr_hold_ev, ovr_off_ev, ovr_lock_ev, field_ev;
  always_comb begin
    gate_next = gate_reg;
    late_ev = 1'b0;
    pwait_ev = 1'b0;
    ovr_cs_ev = 1'b0;
    ovr_hold_ev = 1'b0;
    ovr_off_ev = 1'b0;
    ovr_lock_ev = 1'b0;
    field_ev = 1'b0;
    unique case (gate_reg)
      fault_supervisor_pkg::G_IDLE: begin
        if (fld_s) field_ev = 1'b1;
        else if (cs_s && !prev_cs_reg) gate_next = fault_supervisor_pkg::G_ARMED;
      end
      fault_supervisor_pkg::G_ARMED: begin
        if (!cs_s) gate_next = fault_supervisor_pkg::G_IDLE;
        else if (fld_s) gate_next = fault_supervisor_pkg::G_OVERRIDE;
        else if (gate_ms_reg >= win_ms) gate_next = fault_supervisor_pkg::G_PWAIT;
      end
      fault_supervisor_pkg::G_PWAIT: begin
        if (fld_s) late_ev = 1'b1;
        else if (!cs_s) gate_next = fault_supervisor_pkg::G_IDLE;
        else if (gate_ms_reg >= fault_supervisor_pkg::PWAIT_MS) pwait_ev = 1'b1;
      end
      fault_supervisor_pkg::G_OVERRIDE: begin
        if (!fld_s) gate_next = fault_supervisor_pkg::G_DONE;
        else if (gate_ms_reg >= fault_supervisor_pkg::OVR_LOCK_MS) ovr_lock_ev = 1'b1;
        else if (gate_ms_reg >= fault_supervisor_pkg::OVR_OFF_MS) ovr_off_ev = 1'b1;
        else if (!cs_s) ovr_cs_ev = 1'b1;
        else if (dual && !hold_s) ovr_hold_ev = 1'b1;
      end
      fault_supervisor_pkg::G_DONE: begin
        if (!cs_s) gate_next = fault_supervisor_pkg::G_IDLE;
      end
      default: gate_next = fault_supervisor_pkg::G_IDLE;
    endcase
  end

  // The wait-mode hour counts from the start signal, so the arming time runs on into it
  logic gate_run;
  always_comb begin
    gate_run = (gate_next == gate_reg) && (gate_reg != fault_supervisor_pkg::G_IDLE);
    if (gate_reg == fault_supervisor_pkg::G_ARMED && gate_next == fault_supervisor_pkg::G_PWAIT) begin
      gate_run = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      gate_reg <= fault_supervisor_pkg::G_IDLE;
      gate_ms_reg <= '0;
      prev_cs_reg <= 1'b0;
    end else begin
      // Gating is frozen once locked so a stuck input cannot walk the sequence
      if (!locked_reg) gate_reg <= gate_next;
      gate_ms_reg <= bump(gate_ms_reg, gate_run, tick);
      prev_cs_reg <= cs_s;
    end
  end

  // Read-back history is not reset; it only compares the lines against themselves
  always_ff @(posedge CLK) begin
    prev_rb_reg <= rb_s;
  end

  // ------------------------------------------------------------
  // Fault priority and code
  // ------------------------------------------------------------
  logic [2:0] mism, tog;
  assign mism = drv_s ^ rb_s;
  assign tog = rb_s ^ prev_rb_reg;

  logic off_ev, lock_ev;
  fault_supervisor_pkg::code_t code_ev;
  logic [fault_supervisor_pkg::EV_W-1:0] ev;
  always_comb begin
    code_ev = fault_supervisor_pkg::C_NONE;
    lock_ev = 1'b0;
    ev = '0;
    if (ovh_s) begin
      code_ev = fault_supervisor_pkg::C_OVERV_HI;
      lock_ev = 1'b1;
    end else if (mchg_s) begin
      code_ev = fault_supervisor_pkg::C_MODE_CHG;
      lock_ev = 1'b1;
    end else if (ovr_lock_ev) begin
      code_ev = fault_supervisor_pkg::C_OVR_TIME;
      lock_ev = 1'b1;
    end else if (gnd_s[0]) code_ev = fault_supervisor_pkg::C_GND_A;
    else if (vcc_s[0]) code_ev = fault_supervisor_pkg::C_VCC_A;
    else if (gnd_s[1]) code_ev = fault_supervisor_pkg::C_GND_B;
    else if (vcc_s[1]) code_ev = fault_supervisor_pkg::C_VCC_B;
    else if (ofl_s[0]) code_ev = fault_supervisor_pkg::C_OUT_U1;
    else if (ofl_s[1]) code_ev = fault_supervisor_pkg::C_OUT_U2;
    else if (uv_s) code_ev = fault_supervisor_pkg::C_UNDERV;
    else if (ov_s) code_ev = fault_supervisor_pkg::C_OVERV;
    else if (th_s) code_ev = fault_supervisor_pkg::C_TEMP_HI;
    else if (tl_s) code_ev = fault_supervisor_pkg::C_TEMP_LO;
    else if (mism[0] || joint_toggle(tog, 0)) code_ev = fault_supervisor_pkg::C_LINE0;
    else if (mism[1] || joint_toggle(tog, 1)) code_ev = fault_supervisor_pkg::C_LINE1;
    else if (mism[2] || joint_toggle(tog, 2)) code_ev = fault_supervisor_pkg::C_LINE2;
    else if (!locked_reg && btn_ms_reg > fault_supervisor_pkg::RST_HOLD_MS) code_ev = fault_supervisor_pkg::C_RST_HOLD;
    else if (cfg_s) code_ev = fault_supervisor_pkg::C_BEAM_CFG;
    else if (resp_s) code_ev = fault_supervisor_pkg::C_RESP;
    else if (blk_s) code_ev = fault_supervisor_pkg::C_BLANK;
    else if (!locked_reg) begin
      if (late_ev) code_ev = fault_supervisor_pkg::C_LATE;
      else if (pwait_ev) code_ev = fault_supervisor_pkg::C_PWAIT;
      else if (ovr_cs_ev) code_ev = fault_supervisor_pkg::C_OVR_START;
      else if (ovr_hold_ev) code_ev = fault_supervisor_pkg::C_OVR_HOLD;
      else if (ovr_off_ev) code_ev = fault_supervisor_pkg::C_OVR_TIME;
      else if (dual && skew_ms_reg > fault_supervisor_pkg::SKEW_MS) code_ev = fault_supervisor_pkg::C_SKEW;
      else if (field_ev || sync_ms_reg > fault_supervisor_pkg::SYNC_MS) code_ev = fault_supervisor_pkg::C_FIELD;
    end
    off_ev = (code_ev != fault_supervisor_pkg::C_NONE);
    ev[fault_supervisor_pkg::EV_OUTPUT] = |{gnd_s, vcc_s, ofl_s};
    ev[fault_supervisor_pkg::EV_SUPPLY] = uv_s | ov_s | ovh_s;
    ev[fault_supervisor_pkg::EV_TEMP] = th_s | tl_s;
    ev[fault_supervisor_pkg::EV_LINE] = (code_ev >= fault_supervisor_pkg::C_LINE0) && (code_ev <= fault_supervisor_pkg::C_LINE2);
    ev[fault_supervisor_pkg::EV_BUTTON] = code_ev == fault_supervisor_pkg::C_RST_HOLD;
    ev[fault_supervisor_pkg::EV_CONFIG] = cfg_s | resp_s | blk_s;
    ev[fault_supervisor_pkg::EV_GATING] = off_ev && code_ev >= fault_supervisor_pkg::C_LATE;
    ev[fault_supervisor_pkg::EV_LOCK] = lock_ev;
  end

  // ------------------------------------------------------------
  // Output state, lock and display
  // ------------------------------------------------------------
  logic off_reg;
  fault_supervisor_pkg::code_t code_reg;
  logic clr_wr;
  assign clr_wr = reg_write(WR, ADDR, fault_supervisor_pkg::A_CLEAR) && WDATA[0];

  always_ff @(posedge CLK) begin
    if (RST) begin
      locked_reg <= 1'b0;
    end else if (lock_ev) begin
      locked_reg <= 1'b1;
    end
  end

  // Clearing only works once the cause is gone; a persisting fault reasserts at once
  always_ff @(posedge CLK) begin
    if (RST) begin
      off_reg <= 1'b1;
      code_reg <= fault_supervisor_pkg::C_NONE;
    end else if (off_ev) begin
      off_reg <= 1'b1;
      if (!locked_reg) code_reg <= code_ev;
    end else if (!locked_reg && (clr_wr || (btn_s && btn_ms_reg == '0))) begin
      off_reg <= 1'b0;
      code_reg <= fault_supervisor_pkg::C_NONE;
    end
  end

  assign SAFETY_OUTPUT_A = !off_reg && !locked_reg;
  assign SAFETY_OUTPUT_B = !off_reg && !locked_reg;
  assign LOCKED = locked_reg;
  assign DISPLAY_LETTER = (code_reg == fault_supervisor_pkg::C_NONE) ? 8'h00 : fault_supervisor_pkg::LETTER_E;
  assign DISPLAY_CODE = code_reg;

  // ------------------------------------------------------------
  // Registers and interrupt
  // ------------------------------------------------------------
  logic [fault_supervisor_pkg::EV_W-1:0] stat_reg, mask_reg;
  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_reg <= '0;
    end else begin
      // A new event wins over a write-one-to-clear in the same cycle
      stat_reg <= (stat_reg & ~(reg_write(WR, ADDR, fault_supervisor_pkg::A_STATUS) ?
                   WDATA[fault_supervisor_pkg::EV_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mask_reg <= '0;
    end else if (reg_write(WR, ADDR, fault_supervisor_pkg::A_MASK)) begin
      mask_reg <= WDATA[fault_supervisor_pkg::EV_W-1:0];
    end
  end

  // Mode writes are refused once locked
  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_reg <= fault_supervisor_pkg::MODE_RST;
    end else if (reg_write(WR, ADDR, fault_supervisor_pkg::A_MODE) && !locked_reg) begin
      mode_reg <= WDATA[2:0];
    end
  end

  // Level output: stays high until software clears the status bit or masks it
  assign IRQ = |(stat_reg & mask_reg);

  always_ff @(posedge CLK) begin
    if (RST) RDATA <= '0;
    else if (RD) begin
      unique case (ADDR)
        fault_supervisor_pkg::A_STATUS: RDATA <= {24'h0, stat_reg};
        fault_supervisor_pkg::A_MASK: RDATA <= {24'h0, mask_reg};
        fault_supervisor_pkg::A_CODE: RDATA <= {22'h0, locked_reg, off_reg, code_reg};
        fault_supervisor_pkg::A_MODE: RDATA <= {29'h0, mode_reg};
        default: RDATA <= '0;
      endcase
    end else RDATA <= '0;
  end

endmodule : fault_and_gating_supervisor

// ### supervisor_checker.sv
`timescale 1ns/1ps
module supervisor_checker (
  input logic CLK,
  input logic RST,
  input logic [1:0] GND_SHORT,
  input logic [1:0] VCC_SHORT,
  input logic [1:0] OUTPUT_FAULT,
  input logic UNDERVOLT,
  input logic OVERVOLT,
  input logic OVERVOLT_HIGH,
  input logic TEMP_HIGH,
  input logic TEMP_LOW,
  input logic MODE_CHANGE,
  input logic BEAM_CFG_FAULT,
  input logic RESPONSE_OVERRUN,
  input logic BLANK_OVERLAP,
  input logic SAFETY_OUTPUT_A,
  input logic SAFETY_OUTPUT_B,
  input logic LOCKED,
  input logic [7:0] DISPLAY_LETTER,
  input logic [7:0] DISPLAY_CODE
);
  // ------------------------------------------------------------
  // Fault reaction: two sync flops plus the output register
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic both_off;
  assign both_off = !SAFETY_OUTPUT_A && !SAFETY_OUTPUT_B;
  AST_SHORT_OFF: assert property ((GND_SHORT != 2'h0 || VCC_SHORT != 2'h0) |-> ##3 both_off)
    else $error("short flag did not turn outputs off");
  AST_STAGE_OFF: assert property (OUTPUT_FAULT != 2'h0 |-> ##3 both_off)
    else $error("output stage fault did not turn outputs off");
  AST_SUPPLY_OFF: assert property (UNDERVOLT || OVERVOLT |-> ##3 both_off)
    else $error("supply flag did not turn outputs off");
  AST_OVERV_LOCK: assert property (OVERVOLT_HIGH |-> ##3 LOCKED && both_off)
    else $error("high overvoltage did not lock");
  AST_TEMP_OFF: assert property (TEMP_HIGH || TEMP_LOW |-> ##3 both_off)
    else $error("temperature flag did not turn outputs off");
  AST_MODE_LOCK: assert property (MODE_CHANGE |-> ##3 LOCKED)
    else $error("mode change did not lock");
  AST_TEACH_OFF: assert property (BEAM_CFG_FAULT || RESPONSE_OVERRUN || BLANK_OVERLAP |-> ##3 both_off)
    else $error("configuration fault did not turn outputs off");
  AST_LETTER: assert property (DISPLAY_LETTER == ((DISPLAY_CODE != 8'h00) ? 8'h45 : 8'h00))
    else $error("display letter does not follow the code");
  AST_LOCK_OFF: assert property (LOCKED |-> both_off)
    else $error("outputs on while locked");
  AST_LOCK_HOLD: assert property (LOCKED |=> LOCKED && $stable(DISPLAY_CODE))
    else $error("lock left or code changed without reset");
  cover property ($rose(LOCKED));
  cover property (DISPLAY_CODE == 8'h69 && both_off);
  cover property ($rose(SAFETY_OUTPUT_A));
endmodule : supervisor_checker

bind fault_and_gating_supervisor supervisor_checker supervisor_checker_inst (
  .CLK(CLK), .RST(RST), .GND_SHORT(GND_SHORT), .VCC_SHORT(VCC_SHORT), .OUTPUT_FAULT(OUTPUT_FAULT),
  .UNDERVOLT(UNDERVOLT), .OVERVOLT(OVERVOLT), .OVERVOLT_HIGH(OVERVOLT_HIGH), .TEMP_HIGH(TEMP_HIGH),
  .TEMP_LOW(TEMP_LOW), .MODE_CHANGE(MODE_CHANGE), .BEAM_CFG_FAULT(BEAM_CFG_FAULT),
  .RESPONSE_OVERRUN(RESPONSE_OVERRUN), .BLANK_OVERLAP(BLANK_OVERLAP), .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A),
  .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B), .LOCKED(LOCKED), .DISPLAY_LETTER(DISPLAY_LETTER), .DISPLAY_CODE(DISPLAY_CODE)
);

// ### machine_controller_model.sv
`timescale 1ns/1ps
module machine_controller_model (
  input logic CLK,
  input logic RST,
  input logic go,
  input logic hold_en,
  input logic [11:0] lag,
  output logic GATING_START,
  output logic GATING_HOLD_SIGNAL
);
  // ------------------------------------------------------------
  // Hold trails start by lag cycles, so skew is set on purpose
  // ------------------------------------------------------------
  logic [11:0] cnt_reg;
  logic hold_tgt;
  assign hold_tgt = go && hold_en;
  always_ff @(posedge CLK) begin
    if (RST) begin
      GATING_START <= 1'b0;
      GATING_HOLD_SIGNAL <= 1'b0;
      cnt_reg <= 12'h000;
    end else begin
      GATING_START <= go;
      if (hold_tgt == GATING_HOLD_SIGNAL) begin
        cnt_reg <= 12'h000;
      end else if (cnt_reg >= lag) begin
        GATING_HOLD_SIGNAL <= hold_tgt;
        cnt_reg <= 12'h000;
      end else begin
        cnt_reg <= cnt_reg + 12'h001;
      end
    end
  end
endmodule : machine_controller_model

// ### tb_fault_and_gating_supervisor.sv
`timescale 1ns/1ps
module tb_fault_and_gating_supervisor;
  // ------------------------------------------------------------
  // Stimulus and instances; TK cycles stand for one millisecond
  // ------------------------------------------------------------
  localparam int TK = 2;
  localparam logic [7:0] CODES [16] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h14, 8'h15,
    8'h18, 8'h19, 8'h22, 8'h23, 8'h24, 8'h60, 8'h61, 8'h62};
  localparam int EVB [16] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 2, 3, 3, 3, 5, 5, 5};
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic [15:0] flt = 16'h0000;
  logic [2:0] LINE_DRIVE = 3'h5;
  logic RESTART_BUTTON = 1'b0, MODE_CHANGE = 1'b0, OVERVOLT_HIGH = 1'b0, FIELD_BROKEN = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0, RD = 1'b0, go = 1'b0, hold_en = 1'b1;
  logic [11:0] lag = 12'h000;
  logic [31:0] RDATA;
  logic SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, LOCKED, IRQ, GATING_START, GATING_HOLD_SIGNAL;
  logic [7:0] DISPLAY_LETTER, DISPLAY_CODE;
  int fails = 0;
  int checks_done = 0;
  always #10 CLK = ~CLK;
  fault_and_gating_supervisor #(.TICK(TK)) fault_and_gating_supervisor_inst (.CLK(CLK), .RST(RST),
    .GND_SHORT({flt[2], flt[0]}), .VCC_SHORT({flt[3], flt[1]}), .OUTPUT_FAULT(flt[5:4]),
    .UNDERVOLT(flt[6]), .OVERVOLT(flt[7]), .OVERVOLT_HIGH(OVERVOLT_HIGH), .TEMP_HIGH(flt[8]),
    .TEMP_LOW(flt[9]), .LINE_DRIVE(LINE_DRIVE), .LINE_READBACK(LINE_DRIVE ^ flt[12:10]),
    .RESTART_BUTTON(RESTART_BUTTON), .MODE_CHANGE(MODE_CHANGE), .BEAM_CFG_FAULT(flt[13]),
    .RESPONSE_OVERRUN(flt[14]), .BLANK_OVERLAP(flt[15]), .FIELD_BROKEN(FIELD_BROKEN), .SYNC_BROKEN(1'b0),
    .GATING_START(GATING_START), .GATING_HOLD_SIGNAL(GATING_HOLD_SIGNAL), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SAFETY_OUTPUT_A(SAFETY_OUTPUT_A), .SAFETY_OUTPUT_B(SAFETY_OUTPUT_B),
    .LOCKED(LOCKED), .DISPLAY_LETTER(DISPLAY_LETTER), .DISPLAY_CODE(DISPLAY_CODE), .IRQ(IRQ));
  machine_controller_model machine_controller_model_inst (.CLK(CLK), .RST(RST), .go(go), .hold_en(hold_en),
    .lag(lag), .GATING_START(GATING_START), .GATING_HOLD_SIGNAL(GATING_HOLD_SIGNAL));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    check(RDATA, exp);
  endtask : rdchk
  task automatic off_code(input logic [7:0] code);
    check({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B}, 2'b00);
    check(DISPLAY_CODE, code);
    check(DISPLAY_LETTER, 8'h45);
  endtask : off_code
  task automatic wait_off(input int lim);
    int i;
    for (i = 0; i < lim && SAFETY_OUTPUT_A !== 1'b0; i++) @(posedge CLK);
    #1;
    if (i == lim) begin
      fails++;
      complete_run();
    end
  endtask : wait_off
  // Faults must be gone and the gating sequence idle before a clear can succeed
  task automatic recover;
    @(posedge CLK);
    flt <= 16'h0000;
    FIELD_BROKEN <= 1'b0;
    go <= 1'b0;
    hold_en <= 1'b1;
    cyc(int'(lag) + 10);
    wr(4'h0, 32'hff);
    wr(4'h4, 32'h1);
    cyc(4);
    check({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B}, 2'b11);
  endtask : recover
  task automatic do_reset;
    @(posedge CLK);
    RST <= 1'b1;
    MODE_CHANGE <= 1'b0;
    OVERVOLT_HIGH <= 1'b0;
    cyc(3);
    @(posedge CLK);
    RST <= 1'b0;
  endtask : do_reset
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic s_reset;
    check({SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, LOCKED, IRQ, DISPLAY_CODE}, 12'h000);
    rdchk(4'h3, 32'h1);
    rdchk(4'hf, 32'h0);
    recover();
  endtask : s_reset
  task automatic s_table;
    for (int i = 0; i < 16; i++) begin
      @(posedge CLK);
      flt <= 16'h0001 << i;
      cyc(5);
      off_code(CODES[i]);
      rdchk(4'h0, 32'h1 << EVB[i]);
      recover();
    end
  endtask : s_table
  task automatic s_irq;
    wr(4'h1, 32'h4);
    @(posedge CLK);
    flt <= 16'h0040;
    cyc(5);
    check(IRQ, 1'b0);
    @(posedge CLK);
    flt <= 16'h0140;
    cyc(5);
    check(IRQ, 1'b1);
    @(posedge CLK);
    flt <= 16'h0000;
    // Let the flag leave the synchroniser, or it sets the bit again beside the clear
    cyc(3);
    wr(4'h0, 32'h4);
    cyc(2);
    check(IRQ, 1'b0);
    rdchk(4'h0, 32'h2);
    recover();
  endtask : s_irq
  task automatic s_lock;
    @(posedge CLK);
    MODE_CHANGE <= 1'b1;
    cyc(5);
    check({LOCKED, DISPLAY_CODE}, 9'h141);
    @(posedge CLK);
    MODE_CHANGE <= 1'b0;
    RESTART_BUTTON <= 1'b1;
    cyc(3);
    @(posedge CLK);
    RESTART_BUTTON <= 1'b0;
    wr(4'h4, 32'h1);
    wr(4'h3, 32'h4);
    cyc(5);
    check({LOCKED, SAFETY_OUTPUT_A, SAFETY_OUTPUT_B, DISPLAY_CODE}, 11'h441);
    rdchk(4'h3, 32'h1);
    do_reset();
    @(posedge CLK);
    OVERVOLT_HIGH <= 1'b1;
    cyc(5);
    check({LOCKED, DISPLAY_CODE}, 9'h116);
    do_reset();
    recover();
  endtask : s_lock
  task automatic s_late;
    wr(4'h3, 32'h4);
    @(posedge CLK);
    go <= 1'b1;
    cyc(2000 * TK + 50);
    check(SAFETY_OUTPUT_A, 1'b1);
    @(posedge CLK);
    FIELD_BROKEN <= 1'b1;
    cyc(5);
    off_code(8'h64);
    recover();
  endtask : s_late
  task automatic s_override(input logic drop_hold);
    wr(4'h3, 32'h6);
    @(posedge CLK);
    go <= 1'b1;
    cyc(10);
    @(posedge CLK);
    FIELD_BROKEN <= 1'b1;
    cyc(10);
    check(SAFETY_OUTPUT_A, 1'b1);
    @(posedge CLK);
    if (drop_hold) hold_en <= 1'b0;
    else begin
      // Hold trails the start drop, so the start signal alone is seen falling
      go <= 1'b0;
      lag <= 12'h014;
    end
    cyc(6);
    off_code(drop_hold ? 8'h67 : 8'h66);
    recover();
    lag <= 12'h000;
  endtask : s_override
  task automatic s_skew;
    wr(4'h3, 32'h1);
    @(posedge CLK);
    lag <= 12'd1100;
    go <= 1'b1;
    cyc(900);
    check(SAFETY_OUTPUT_A, 1'b1);
    wait_off(400);
    off_code(8'h69);
    recover();
    lag <= 12'h000;
  endtask : s_skew
  task automatic s_field;
    @(posedge CLK);
    FIELD_BROKEN <= 1'b1;
    cyc(5);
    off_code(8'h70);
    recover();
  endtask : s_field
  initial begin
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    cyc(2);
    s_reset();
    s_table();
    s_irq();
    s_lock();
    s_late();
    s_override(1'b1);
    s_override(1'b0);
    s_skew();
    s_field();
    complete_run();
  end
endmodule : tb_fault_and_gating_supervisor
